// file: design/spa_pkg.sv
// constants for the pause source address and fabric indirect command block
//
// Contract
// - indirect write changes only target bytes whose lane-select bit is set
// - lane bit 3 covers data 31:24, bit 2 23:16, bit 1 15:8, bit 0 7:0
// - 16-bit target index in command bits 15:0 addresses the fabric; resets zero
// - high register bits 15:0 hold address bits 47:32, reset all ones
// - low register holds address bits 31:0, reset FF0F8000
// - power-on loader fills both registers only if programmed EEPROM found
// - loader puts EEPROM byte 05h in high 7:0, 06h in high 15:8
// - loader puts EEPROM bytes 01h..04h into low register bytes 0..3
// - host writes to address registers accepted only after loading finishes
// - high bit 22, reset clear, enables a distinct address per port
// - per-port address bits 41:40 come from fields 21:20, 19:18, 17:16
// - with per-port mode, shared bits 41:40 are replaced by per-port values
// - first line byte is low 7:0, sixth byte is high 15:8
// - writing pending bit starts access; self-clears on completion; host waits
// - direction bit zero selects write, one selects read
`default_nettype none
package spa_pkg;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [11:0] ADDR_HIGH_OFS = 12'h1F0;
   localparam logic [11:0] ADDR_LOW_OFS = 12'h1F4;
   localparam logic [11:0] CMD_OFS = 12'h1A4;
   localparam logic [11:0] DATA_OFS = 12'h1A0;
   localparam logic [31:0] ADDR_HIGH_RST = 32'h0024FFFF;
   localparam logic [31:0] ADDR_LOW_RST = 32'hFF0F8000;
   localparam logic [31:0] ADDR_HIGH_MASK = 32'h007FFFFF;
   localparam int PENDING_BIT = 31;
   localparam int DIR_BIT = 30;
   localparam int INC_BIT = 29;
   localparam int DEC_BIT = 28;
   localparam int LANE_LSB = 16;
   localparam int PER_PORT_BIT = 22;
   localparam int PORT_FIELD_LSB = 16;
   localparam int SHARED_4140_LSB = 8;
   localparam int EE_FIRST_BYTE = 1;
   localparam int EE_BYTES = 6;
endpackage
`default_nettype wire

// file: design/spa_lane_merge.sv
// byte-lane merge for indirect fabric writes
`default_nettype none
module spa_lane_merge #(
   parameter int LANES = 4
) (
   input wire logic [LANES*8-1:0] old_in,
   input wire logic [LANES*8-1:0] new_in,
   input wire logic [LANES-1:0] lane_in,
   output logic [LANES*8-1:0] merged_out
);
   timeunit 1ns;
   timeprecision 1ps;
   genvar i;
   generate
      for (i = 0; i < LANES; i++)
      begin : g_lane
         // lane i governs bits 8i+7:8i
         assign merged_out[i*8 +: 8] = lane_in[i] ? new_in[i*8 +: 8] : old_in[i*8 +: 8];
      end
   endgenerate
endmodule
`default_nettype wire

// file: design/spa_regs.sv
// host register file: pause source address pair and indirect fabric command
`default_nettype none
module spa_regs (
   input wire logic clk_in,
   input wire logic resetn_in,
   // host register port
   input wire logic [11:0] reg_addr_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic [31:0] reg_wdata_in,
   output logic [31:0] reg_rdata_out,
   // eeprom loader
   input wire logic ee_load_in,
   input wire logic [2:0] ee_index_in,
   input wire logic [7:0] ee_byte_in,
   input wire logic ee_programmed_in,
   input wire logic ee_done_in,
   // switch fabric register space
   output logic fab_req_out,
   output logic fab_write_out,
   output logic [15:0] fab_index_out,
   output logic [31:0] fab_wdata_out,
   output logic [3:0] fab_lane_out,
   input wire logic [31:0] fab_rdata_in,
   input wire logic fab_ack_in,
   // per-port pause source addresses, port p in bits 48p+47:48p
   output logic [143:0] pause_addr_out
);
   timeunit 1ns;
   timeprecision 1ps;
   // ************************************************************
   // state
   // ************************************************************
   typedef enum logic [1:0] {
      SPA_IDLE = 2'b00,
      SPA_READ_OLD = 2'b01,
      SPA_BUSY = 2'b10
   } spa_state_t;

   spa_state_t state_q;
   logic [31:0] high_q;
   logic [31:0] low_q;
   logic [31:0] cmd_q;
   logic [31:0] data_q;
   logic [31:0] merged_q;
   logic init_done_q;
   logic [31:0] merged;
   logic wr_high;
   logic wr_low;
   logic wr_cmd;
   logic wr_data;
   logic rd_data;
   logic auto_step;
   logic start;

   always_comb
   begin
      wr_high = 1'b0;
      wr_low = 1'b0;
      wr_cmd = 1'b0;
      wr_data = 1'b0;
      rd_data = 1'b0;
      if (reg_addr_in == spa_pkg::ADDR_HIGH_OFS)
      begin
         wr_high = reg_wr_in && init_done_q;
      end
      else if (reg_addr_in == spa_pkg::ADDR_LOW_OFS)
      begin
         wr_low = reg_wr_in && init_done_q;
      end
      else if (reg_addr_in == spa_pkg::CMD_OFS)
      begin
         wr_cmd = reg_wr_in;
      end
      else if (reg_addr_in == spa_pkg::DATA_OFS)
      begin
         wr_data = reg_wr_in;
         rd_data = reg_rd_in;
      end
   end

   assign auto_step = cmd_q[spa_pkg::INC_BIT] || cmd_q[spa_pkg::DEC_BIT];
   // a new access only starts when none is pending; host is expected to wait
   assign start = (state_q == SPA_IDLE) && !cmd_q[spa_pkg::PENDING_BIT]
      && ((wr_cmd && reg_wdata_in[spa_pkg::PENDING_BIT])
      || (auto_step && (wr_data || rd_data)));

   // ************************************************************
   // address register pair with power-on load
   // ************************************************************
   always_ff @(posedge clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         init_done_q <= 1'b0;
      end
      else if (ee_done_in)
      begin
         init_done_q <= 1'b1;
      end
   end

   always_ff @(posedge clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         high_q <= spa_pkg::ADDR_HIGH_RST;
         low_q <= spa_pkg::ADDR_LOW_RST;
      end
      else if (!init_done_q)
      begin
         // bytes 1..4 land in low, 5..6 in high, lowest byte first
         if (ee_load_in && ee_programmed_in)
         begin
            if (ee_index_in == 3'(spa_pkg::EE_FIRST_BYTE))
               low_q[7:0] <= ee_byte_in;
            else if (ee_index_in == 3'(spa_pkg::EE_FIRST_BYTE + 1))
               low_q[15:8] <= ee_byte_in;
            else if (ee_index_in == 3'(spa_pkg::EE_FIRST_BYTE + 2))
               low_q[23:16] <= ee_byte_in;
            else if (ee_index_in == 3'(spa_pkg::EE_FIRST_BYTE + 3))
               low_q[31:24] <= ee_byte_in;
            else if (ee_index_in == 3'(spa_pkg::EE_FIRST_BYTE + 4))
               high_q[7:0] <= ee_byte_in;
            else if (ee_index_in == 3'(spa_pkg::EE_BYTES))
               high_q[15:8] <= ee_byte_in;
         end
      end
      else
      begin
         if (wr_high)
            high_q <= reg_wdata_in & spa_pkg::ADDR_HIGH_MASK;
         if (wr_low)
            low_q <= reg_wdata_in;
      end
   end

   // ************************************************************
   // pause source address per port
   // ************************************************************
   genvar p;
   generate
      for (p = 0; p < 3; p++)
      begin : g_port
         logic [1:0] pair_41_40;
         // per-port mode swaps only bits 41:40; the rest of the upper half stays shared
         assign pair_41_40 = high_q[spa_pkg::PER_PORT_BIT]
            ? high_q[spa_pkg::PORT_FIELD_LSB + 2*p +: 2]
            : high_q[spa_pkg::SHARED_4140_LSB +: 2];
         // line order: low 7:0 first ... high 15:8 sixth
         assign pause_addr_out[p*48 +: 48] = {high_q[15:spa_pkg::SHARED_4140_LSB + 2],
            pair_41_40, high_q[spa_pkg::SHARED_4140_LSB - 1:0], low_q};
      end
   endgenerate

   // ************************************************************
   // indirect fabric access
   // ************************************************************
   spa_lane_merge #(
      .LANES(4)
   ) u_merge (
      .old_in(fab_rdata_in),
      .new_in(data_q),
      .lane_in(cmd_q[spa_pkg::LANE_LSB +: 4]),
      .merged_out(merged)
   );

   always_ff @(posedge clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         state_q <= SPA_IDLE;
         cmd_q <= 32'h00000000;
         data_q <= 32'h00000000;
         merged_q <= 32'h00000000;
      end
      else
      begin
         case (state_q)
            SPA_IDLE:
            begin
               if (wr_cmd && !cmd_q[spa_pkg::PENDING_BIT])
                  cmd_q <= {reg_wdata_in[31:28], 8'h00, reg_wdata_in[19:0]};
               if (wr_data && !cmd_q[spa_pkg::PENDING_BIT])
                  data_q <= reg_wdata_in;
               if (start)
               begin
                  cmd_q[spa_pkg::PENDING_BIT] <= 1'b1;
                  if (rd_data && auto_step)
                     cmd_q[spa_pkg::DIR_BIT] <= 1'b1;
                  else if (wr_data && auto_step)
                     cmd_q[spa_pkg::DIR_BIT] <= 1'b0;
                  // read-modify-write keeps unselected bytes of the target
                  state_q <= SPA_READ_OLD;
               end
            end
            SPA_READ_OLD:
            begin
               if (fab_ack_in)
               begin
                  // merged word held on a flop so write data stands for the whole phase
                  merged_q <= merged;
                  if (cmd_q[spa_pkg::DIR_BIT])
                  begin
                     data_q <= fab_rdata_in;
                     cmd_q[spa_pkg::PENDING_BIT] <= 1'b0;
                     state_q <= SPA_IDLE;
                  end
                  else
                     state_q <= SPA_BUSY;
               end
            end
            SPA_BUSY:
            begin
               if (fab_ack_in)
               begin
                  cmd_q[spa_pkg::PENDING_BIT] <= 1'b0;
                  // host sets all lanes for stepping; partial lanes still honoured
                  if (cmd_q[spa_pkg::INC_BIT])
                     cmd_q[15:0] <= cmd_q[15:0] + 16'h0001;
                  else if (cmd_q[spa_pkg::DEC_BIT])
                     cmd_q[15:0] <= cmd_q[15:0] - 16'h0001;
                  state_q <= SPA_IDLE;
               end
            end
            default:
               state_q <= SPA_IDLE;
         endcase
      end
   end

   assign fab_req_out = (state_q != SPA_IDLE);
   assign fab_write_out = (state_q == SPA_BUSY);
   assign fab_index_out = cmd_q[15:0];
   assign fab_wdata_out = merged_q;
   assign fab_lane_out = (state_q == SPA_BUSY) ? cmd_q[spa_pkg::LANE_LSB +: 4] : 4'h0;

   always_comb
   begin
      reg_rdata_out = 32'h00000000;
      if (reg_addr_in == spa_pkg::ADDR_HIGH_OFS)
         reg_rdata_out = high_q & spa_pkg::ADDR_HIGH_MASK;
      else if (reg_addr_in == spa_pkg::ADDR_LOW_OFS)
         reg_rdata_out = low_q;
      else if (reg_addr_in == spa_pkg::CMD_OFS)
         reg_rdata_out = cmd_q;
      else if (reg_addr_in == spa_pkg::DATA_OFS)
         reg_rdata_out = data_q;
   end
endmodule
`default_nettype wire

// file: verification/spa_sva.sv
// concurrent checks on the register block ports
`default_nettype none
module spa_sva (
   input wire logic clk_in,
   input wire logic resetn_in,
   input wire logic [11:0] reg_addr_in,
   input wire logic reg_wr_in,
   input wire logic [31:0] reg_wdata_in,
   input wire logic [31:0] reg_rdata_out,
   input wire logic fab_req_out,
   input wire logic fab_write_out,
   input wire logic [15:0] fab_index_out,
   input wire logic [3:0] fab_lane_out,
   input wire logic fab_ack_in,
   input wire logic [143:0] pause_addr_out
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!resetn_in);
   logic hi;
   logic cmd;
   logic [31:0] q;
   assign hi = reg_addr_in == spa_pkg::ADDR_HIGH_OFS;
   assign cmd = reg_addr_in == spa_pkg::CMD_OFS;
   assign q = reg_rdata_out;
   sequence start_s;
      reg_wr_in && cmd && reg_wdata_in[31] && !fab_req_out;
   endsequence
   sequence fetch_s;
      fab_req_out && !fab_write_out;
   endsequence
   a_start_fetch: assert property (start_s |=> fetch_s)
      else $error("access did not open with a fetch");
   a_phase_stands: assert property (fab_req_out && !fab_ack_in |=> fab_req_out &&
      $stable(fab_index_out) && $stable(fab_write_out) && $stable(fab_lane_out))
      else $error("fabric request moved before ack");
   a_lane_idle: assert property (!fab_write_out |-> fab_lane_out == 4'h0)
      else $error("lanes driven outside write phase");
   a_lane_cmd: assert property (fab_write_out && cmd |-> fab_lane_out == q[19:16])
      else $error("lanes differ from command");
   a_index_cmd: assert property (fab_req_out && cmd |-> fab_index_out == q[15:0])
      else $error("index differs from command");
   a_reserved_zero: assert property (hi |-> q[31:23] == 9'h000)
      else $error("reserved high bits not zero");
   a_shared_high: assert property (hi && !q[22] |-> pause_addr_out[47:32] == q[15:0]
      && pause_addr_out[143:128] == q[15:0]) else $error("shared address mismatch");
   a_port_bits: assert property (hi && q[22] |-> pause_addr_out[41:40] == q[17:16]
      && pause_addr_out[89:88] == q[19:18] && pause_addr_out[137:136] == q[21:20])
      else $error("per-port address bits mismatch");
endmodule
bind spa_regs spa_sva spa_sva_i (.*);
`default_nettype wire

// file: verification/spa_fabric_model.sv
// behavioural fabric register space answering indirect accesses
`default_nettype none
module spa_fabric_model (
   input wire logic clk_in,
   input wire logic req_in,
   input wire logic write_in,
   input wire logic [15:0] index_in,
   input wire logic [31:0] wdata_in,
   input wire logic [3:0] delay_in,
   output logic [31:0] rdata_out,
   output logic ack_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0] mem_q [16];
   logic [3:0] wait_q = 4'h0;
   initial
   begin
      foreach (mem_q[i]) mem_q[i] = 32'h5A5A5A5A;
      ack_out = 1'b0;
      rdata_out = 32'h0;
   end
   // read data toggles outside the ack so a stale value never looks valid
   always @(posedge clk_in)
   begin
      rdata_out <= ~rdata_out;
      if (ack_out && write_in)
         mem_q[index_in[3:0]] <= wdata_in;
      if (!req_in || ack_out)
      begin
         wait_q <= 4'h0;
         ack_out <= 1'b0;
      end
      else if (wait_q < delay_in)
         wait_q <= wait_q + 4'h1;
      else
      begin
         ack_out <= 1'b1;
         rdata_out <= mem_q[index_in[3:0]];
      end
   end
endmodule
`default_nettype wire

// file: verification/testbench.sv
// self-checking bench for the pause address and fabric command registers
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [11:0] HI = spa_pkg::ADDR_HIGH_OFS;
   localparam logic [11:0] LO = spa_pkg::ADDR_LOW_OFS;
   localparam logic [11:0] CMD = spa_pkg::CMD_OFS;
   localparam logic [11:0] DAT = spa_pkg::DATA_OFS;
   logic clk_in = 0, resetn_in = 0, wr = 0, ld = 0, prog = 0, done = 0, rs = 0, ack, req, fw;
   logic [11:0] addr = 12'h000;
   logic [31:0] wd = 32'h0, rd, frd, fwd, ex;
   logic [2:0] ei = 3'h0;
   logic [7:0] eb = 8'h00;
   logic [3:0] dly = 4'h0;
   logic [15:0] idx;
   logic [143:0] pa;
   int fail_count = 0, n_compared = 0;
   spa_regs spa_regs_i (.clk_in, .resetn_in, .reg_addr_in(addr), .reg_wr_in(wr),
      .reg_rd_in(rs), .reg_wdata_in(wd), .reg_rdata_out(rd), .ee_load_in(ld),
      .ee_index_in(ei), .ee_byte_in(eb), .ee_programmed_in(prog), .ee_done_in(done),
      .fab_req_out(req), .fab_write_out(fw), .fab_index_out(idx), .fab_wdata_out(fwd),
      .fab_lane_out(), .fab_rdata_in(frd), .fab_ack_in(ack), .pause_addr_out(pa));
   spa_fabric_model spa_fabric_model_i (.clk_in, .req_in(req), .write_in(fw),
      .index_in(idx), .wdata_in(fwd), .delay_in(dly), .rdata_out(frd), .ack_out(ack));
   // ******************************
   // access tasks
   // ******************************
   task automatic finish_test;
      if (fail_count == 0 && n_compared > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input logic [47:0] got, input logic [47:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         fail_count++;
         $display("ERROR %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic w(input logic [11:0] a, input logic [31:0] d);
      @(negedge clk_in) {addr, wd, wr} = {a, d, 1'b1};
      @(negedge clk_in) wr = 1'b0;
   endtask
   task automatic r(input logic [11:0] a, input logic [31:0] e);
      @(negedge clk_in) addr = a;
      #1 chk(rd, e);
   endtask
   task automatic e(input logic [2:0] i, input logic [7:0] b);
      @(negedge clk_in) {ei, eb, ld} = {i, b, 1'b1};
      @(negedge clk_in) ld = 1'b0;
   endtask
   task automatic rdstrobe(input logic [11:0] a);
      @(negedge clk_in) {addr, rs} = {a, 1'b1};
      @(negedge clk_in) rs = 1'b0;
   endtask
   // the pending bit is the only completion signal the host sees
   task automatic idle;
      int n;
      addr = CMD;
      #1;
      for (n = 0; n < 64 && rd[31] !== 1'b0; n++) @(negedge clk_in);
      if (n == 64)
      begin
         fail_count++;
         finish_test;
      end
   endtask
   initial forever #2 clk_in = ~clk_in;
   initial
   begin
      repeat (12) @(negedge clk_in);
      resetn_in = 1'b1;
      r(HI, 32'h0024FFFF);
      r(LO, 32'hFF0F8000);
      r(CMD, 32'h0);
      r(12'h100, 32'h0);
      chk(pa[47:0], 48'hFFFFFF0F8000);
      w(HI, 32'h0);
      w(LO, 32'h0);
      prog = 1'b1;
      for (int i = 1; i <= 6; i++) e(i[2:0], {i[3:0], i[3:0]});
      prog = 1'b0;
      e(3'h6, 8'hAA);
      r(HI, 32'h00246655);
      r(LO, 32'h44332211);
      chk(pa[47:0], 48'h665544332211);
      @(negedge clk_in) done = 1'b1;
      @(negedge clk_in) done = 1'b0;
      w(HI, 32'hFFDB0300);
      r(HI, 32'h005B0300);
      for (int p = 0; p < 3; p++) chk(pa[48*p+32 +: 16], 16'h0300 - 16'h0100 * p[15:0]);
      w(LO, 32'h9ABCDEF0);
      r(LO, 32'h9ABCDEF0);
      chk(pa[95:48], 48'h02009ABCDEF0);
      for (int l = 0; l < 4; l++)
      begin
         dly = l[3:0];
         w(DAT, 32'hDEADBEEF);
         w(CMD, 32'h80000000 | (32'h1 << (16 + l)) | l);
         idle;
         w(CMD, 32'hC0000000 | l);
         idle;
         ex = 32'h5A5A5A5A;
         ex[8*l +: 8] = 8'(32'hDEADBEEF >> (8 * l));
         r(DAT, ex);
      end
      w(CMD, 32'h200F0008);
      w(DAT, 32'h12345678);
      idle;
      r(CMD, 32'h200F0009);
      w(CMD, 32'h100F0009);
      w(DAT, 32'h12345678);
      idle;
      r(CMD, 32'h100F0008);
      w(CMD, 32'h200F0002);
      rdstrobe(DAT);
      idle;
      r(DAT, 32'h5AAD5A5A);
      finish_test;
   end
endmodule
`default_nettype wire
